// [design/mcu_glue.sv]
// Function
// - reserved info window: writes ignored, reads return zero
// - factory info area mapped 0x400-0x47F only while enable bit is one
// - RAM decoded from 0x0800 to 0x07FF plus RAM size
// - flash decoded from 0x40000 minus flash size up to 0x3FFFF
// - access to unimplemented flash page raises illegal-address reset
// - part identity readable as two read-only bytes at 0x1A and 0x1B
// - identity fields: family major, family minor, mask major, mask minor
// - mode strap captured into mode bit as reset releases
// - strap one selects normal single-chip, zero selects special single-chip
// - mode bit shows current mode, software may only make limited changes
// - normal mode fetches from on-chip memory via reset vector
// - special mode activates background debug and on-chip monitor
// - debug enable depends on mode and security state
// - stop instruction enters stop mode
// - stop ends on reset, die link interrupt or unmasked interrupt
// - core and bus clock source selectable between loop and oscillator
// - flash time base derived from bus clock
// - oscillator monitor issues reset on timeout when enabled
// - freeze-capable modules hold status while debug active and freeze on
`timescale 1ns/100ps
`default_nettype none
module mcu_glue #(
	parameter logic [17:0] RAM_SIZE = mcu_glue_pkg::RAM_SIZE_DEF,
	parameter logic [17:0] FLASH_SIZE = mcu_glue_pkg::FLASH_SIZE_DEF,
	// identity values are arbitrary
	parameter logic [3:0] FAM_MAJOR = 4'h5,
	parameter logic [3:0] FAM_MINOR = 4'ha,
	parameter logic [3:0] REV_MAJOR = 4'h2,
	parameter logic [3:0] REV_MINOR = 4'h1,
	parameter int OSC_TIMEOUT_CYC = mcu_glue_pkg::OSC_TIMEOUT_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic mode_strap_bit,
	input wire logic osc_alive_pin,
	input wire logic die_link_interrupt_input,
	input wire logic irq_unmasked,
	input wire logic stop_exec,
	input wire logic secure_state,
	input wire logic [9:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [17:0] bus_addr,
	input wire logic bus_valid,
	input wire logic bus_write,
	output logic sel_periph,
	output logic sel_info,
	output logic sel_ram,
	output logic sel_flash,
	output logic sel_zero,
	output logic illegal_addr_reset,
	output logic osc_mon_reset,
	output logic sys_reset_req,
	output logic mode_normal,
	output logic fetch_internal,
	output logic bdm_active,
	output logic run_monitor,
	output logic debug_enable,
	output logic stop_mode,
	output logic core_clk_run,
	output logic clk_src_osc,
	output logic flash_tick,
	output logic freeze
);
	localparam logic [17:0] RAM_HI = mcu_glue_pkg::RAM_BASE_M1 + RAM_SIZE;
	localparam logic [18:0] FLASH_LO_W = mcu_glue_pkg::FLASH_TOP_P1 - {1'b0, FLASH_SIZE};
	localparam logic [17:0] FLASH_LO = FLASH_LO_W[17:0];
	localparam logic [15:0] PART_ID = {FAM_MAJOR, FAM_MINOR, REV_MAJOR, REV_MINOR};

	sysctl_if ctl_bus();

	// pin synchronisers
	logic [1:0] strap_sync_ff;
	logic [1:0] link_int_sync_ff;
	logic strap_q;
	logic link_int_q;

	// strap keeps sampling through reset so its value is settled at release
	always_ff @(posedge clk_sys) begin
		strap_sync_ff <= {strap_sync_ff[0], mode_strap_bit};
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			link_int_sync_ff <= 2'h0;
		end else begin
			link_int_sync_ff <= {link_int_sync_ff[0], die_link_interrupt_input};
		end
	end
	assign strap_q = strap_sync_ff[1];
	assign link_int_q = link_int_sync_ff[1];

	// reset release detection
	logic in_reset_ff;
	logic rst_release;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			in_reset_ff <= 1'b1;
		end else begin
			in_reset_ff <= 1'b0;
		end
	end
	assign rst_release = in_reset_ff && !rst;

	// register write decode
	logic wr_mode;
	logic wr_mmc;
	logic wr_clk;
	logic wr_presc;

	assign wr_mode = reg_wr && (reg_addr == mcu_glue_pkg::OFS_MODE);
	assign wr_mmc = reg_wr && (reg_addr == mcu_glue_pkg::OFS_MMC);
	assign wr_clk = reg_wr && (reg_addr == mcu_glue_pkg::OFS_CLK);
	assign wr_presc = reg_wr && (reg_addr == mcu_glue_pkg::OFS_PRESC);

	// operating mode
	logic mode_ff;
	logic mode_lock_ff;
	logic nxt_mode;

	always_comb begin
		nxt_mode = mode_ff;
		if (rst_release) begin
			nxt_mode = strap_q;
		end else if (wr_mode && !mode_lock_ff && !mode_ff) begin
			// only special to normal, once; never back to special
			nxt_mode = reg_wdata[mcu_glue_pkg::MODE_BIT];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mode_ff <= 1'b1;
		end else begin
			mode_ff <= nxt_mode;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mode_lock_ff <= 1'b0;
		end else if (wr_mode) begin
			mode_lock_ff <= 1'b1;
		end
	end

	// memory map control
	logic info_window_enable;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			info_window_enable <= 1'b0;
		end else if (wr_mmc) begin
			info_window_enable <= reg_wdata[mcu_glue_pkg::INFO_EN_BIT];
		end
	end

	// clock control
	logic [7:0] clk_ctl_ff;
	logic [7:0] presc_ff;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			clk_ctl_ff <= mcu_glue_pkg::CLK_RST;
		end else if (wr_clk) begin
			clk_ctl_ff <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			presc_ff <= mcu_glue_pkg::PRESC_RST;
		end else if (wr_presc) begin
			presc_ff <= reg_wdata;
		end
	end

	assign clk_src_osc = clk_ctl_ff[mcu_glue_pkg::CLK_OSC_BIT];
	assign ctl_bus.mon_en = clk_ctl_ff[mcu_glue_pkg::CLK_MON_BIT];
	assign ctl_bus.presc = presc_ff;

	osc_monitor #(
		.TIMEOUT_CYC(OSC_TIMEOUT_CYC)
	) u_osc_monitor (
		.clk_sys(clk_sys),
		.rst(rst),
		.osc_alive_pin(osc_alive_pin),
		.ctl(ctl_bus.mon)
	);

	flash_timebase u_flash_timebase (
		.clk_sys(clk_sys),
		.rst(rst),
		.ctl(ctl_bus.tb)
	);

	assign flash_tick = ctl_bus.tick;

	// power state
	mcu_glue_pkg::pwr_t pwr_ff;
	mcu_glue_pkg::pwr_t nxt_pwr;

	always_comb begin
		nxt_pwr = pwr_ff;
		unique case (pwr_ff)
			mcu_glue_pkg::PWR_RUN: begin
				if (stop_exec) begin
					nxt_pwr = mcu_glue_pkg::PWR_STOP;
				end
			end
			mcu_glue_pkg::PWR_STOP: begin
				if (link_int_q || irq_unmasked) begin
					nxt_pwr = mcu_glue_pkg::PWR_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pwr_ff <= mcu_glue_pkg::PWR_RUN;
		end else begin
			pwr_ff <= nxt_pwr;
		end
	end

	assign stop_mode = (pwr_ff == mcu_glue_pkg::PWR_STOP);
	assign core_clk_run = !stop_mode;

	// chip mode effects
	assign mode_normal = mode_ff;
	assign fetch_internal = mode_ff && !rst;
	assign bdm_active = !mode_ff && !rst;
	assign run_monitor = bdm_active;
	assign debug_enable = !mode_ff || !secure_state;
	assign freeze = bdm_active && clk_ctl_ff[mcu_glue_pkg::CLK_FRZ_BIT];

	// global address decode
	logic in_reg;
	logic in_info;
	logic in_ram;
	logic in_flash;
	logic in_flash_gap;

	assign in_reg = (bus_addr <= mcu_glue_pkg::REG_HI);
	assign in_info = (bus_addr >= mcu_glue_pkg::INFO_LO) && (bus_addr <= mcu_glue_pkg::INFO_HI);
	assign in_ram = (bus_addr >= mcu_glue_pkg::RAM_LO) && (bus_addr <= RAM_HI);
	assign in_flash = (bus_addr >= FLASH_LO) && (bus_addr <= mcu_glue_pkg::FLASH_END);
	assign in_flash_gap = (bus_addr >= mcu_glue_pkg::FLASH_SPACE_LO) && (bus_addr < FLASH_LO);

	assign sel_periph = bus_valid && in_reg;
	assign sel_info = bus_valid && in_info && info_window_enable;
	assign sel_ram = bus_valid && in_ram;
	assign sel_flash = bus_valid && in_flash;
	// unmapped reads outside the flash gap and reserved reads answer zero, writes reach no target
	assign sel_zero = bus_valid && !bus_write && !sel_periph && !sel_info && !sel_ram
		&& !sel_flash && !in_flash_gap;

	// illegal address reset
	logic illegal_ff;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			illegal_ff <= 1'b0;
		end else begin
			illegal_ff <= bus_valid && in_flash_gap;
		end
	end

	logic osc_rst_ff;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			osc_rst_ff <= 1'b0;
		end else begin
			osc_rst_ff <= ctl_bus.osc_timeout;
		end
	end

	assign illegal_addr_reset = illegal_ff;
	assign osc_mon_reset = osc_rst_ff;
	assign sys_reset_req = illegal_ff || osc_rst_ff;

	// register read path
	logic [7:0] status;
	logic [7:0] rd_mux;
	logic [7:0] reg_rdata_ff;

	always_comb begin
		status = mcu_glue_pkg::ZERO8;
		status[mcu_glue_pkg::ST_INFO_BIT] = info_window_enable;
		status[mcu_glue_pkg::ST_MODE_BIT] = mode_ff;
		status[mcu_glue_pkg::ST_BDM_BIT] = bdm_active;
		status[mcu_glue_pkg::ST_DBG_BIT] = debug_enable;
		status[mcu_glue_pkg::ST_SEC_BIT] = secure_state;
		status[mcu_glue_pkg::ST_STOP_BIT] = stop_mode;
	end

	always_comb begin
		rd_mux = mcu_glue_pkg::ZERO8;
		unique case (reg_addr)
			mcu_glue_pkg::OFS_MODE: begin
				rd_mux[mcu_glue_pkg::MODE_BIT] = mode_ff;
			end
			mcu_glue_pkg::OFS_MMC: begin
				rd_mux[mcu_glue_pkg::INFO_EN_BIT] = info_window_enable;
			end
			mcu_glue_pkg::OFS_ID_H: begin
				rd_mux = {PART_ID[mcu_glue_pkg::ID_FAM_MAJ_LSB +: 4], PART_ID[mcu_glue_pkg::ID_FAM_MIN_LSB +: 4]};
			end
			mcu_glue_pkg::OFS_ID_L: begin
				rd_mux = {PART_ID[mcu_glue_pkg::ID_REV_MAJ_LSB +: 4], PART_ID[mcu_glue_pkg::ID_REV_MIN_LSB +: 4]};
			end
			mcu_glue_pkg::OFS_CLK: begin
				rd_mux = clk_ctl_ff;
			end
			mcu_glue_pkg::OFS_PRESC: begin
				rd_mux = presc_ff;
			end
			mcu_glue_pkg::OFS_STAT: begin
				rd_mux = status;
			end
			default: begin
				rd_mux = mcu_glue_pkg::ZERO8;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata_ff <= mcu_glue_pkg::ZERO8;
		end else if (reg_rd) begin
			reg_rdata_ff <= rd_mux;
		end else begin
			reg_rdata_ff <= mcu_glue_pkg::ZERO8;
		end
	end

	assign reg_rdata = reg_rdata_ff;
endmodule
`default_nettype wire

// [design/mcu_glue_pkg.sv]
package mcu_glue_pkg;
	localparam int ADDR_W = 18;
	localparam int REG_AW = 10;
	localparam int DATA_W = 8;
	// global map
	localparam logic [17:0] REG_LO = 18'h0_0000;
	localparam logic [17:0] REG_HI = 18'h0_03ff;
	localparam logic [17:0] INFO_LO = 18'h0_0400;
	localparam logic [17:0] INFO_HI = 18'h0_047f;
	localparam logic [17:0] RAM_LO = 18'h0_0800;
	localparam logic [17:0] RAM_BASE_M1 = 18'h0_07ff;
	localparam logic [18:0] FLASH_TOP_P1 = 19'h4_0000;
	localparam logic [17:0] FLASH_END = 18'h3_ffff;
	localparam logic [17:0] FLASH_SPACE_LO = 18'h1_0000;
	localparam logic [17:0] RAM_SIZE_DEF = 18'h0_0800;
	localparam logic [17:0] FLASH_SIZE_DEF = 18'h0_8000;
	// register offsets
	localparam logic [9:0] OFS_MODE = 10'h00b;
	localparam logic [9:0] OFS_MMC = 10'h013;
	localparam logic [9:0] OFS_ID_H = 10'h01a;
	localparam logic [9:0] OFS_ID_L = 10'h01b;
	localparam logic [9:0] OFS_CLK = 10'h030;
	localparam logic [9:0] OFS_PRESC = 10'h031;
	localparam logic [9:0] OFS_STAT = 10'h032;
	// field positions
	localparam int MODE_BIT = 7;
	localparam int INFO_EN_BIT = 0;
	localparam int CLK_OSC_BIT = 0;
	localparam int CLK_MON_BIT = 1;
	localparam int CLK_FRZ_BIT = 2;
	localparam int ST_INFO_BIT = 0;
	localparam int ST_MODE_BIT = 1;
	localparam int ST_BDM_BIT = 2;
	localparam int ST_DBG_BIT = 3;
	localparam int ST_SEC_BIT = 4;
	localparam int ST_STOP_BIT = 5;
	localparam int ID_FAM_MAJ_LSB = 12;
	localparam int ID_FAM_MIN_LSB = 8;
	localparam int ID_REV_MAJ_LSB = 4;
	localparam int ID_REV_MIN_LSB = 0;
	// reset values
	localparam logic [7:0] PRESC_RST = 8'h13;
	localparam logic [7:0] CLK_RST = 8'h00;
	localparam logic [7:0] ZERO8 = 8'h00;
	// timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int OSC_TIMEOUT_NS = 100000;
	localparam int OSC_TIMEOUT_CYC = OSC_TIMEOUT_NS / CLK_PERIOD_NS;
	typedef enum logic {PWR_RUN, PWR_STOP} pwr_t;
endpackage

// [design/sysctl_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface sysctl_if;
	logic mon_en;
	logic osc_timeout;
	logic tick;
	logic [7:0] presc;
	modport ctl(output mon_en, output presc, input osc_timeout, input tick);
	modport mon(input mon_en, output osc_timeout);
	modport tb(input presc, output tick);
endinterface
`default_nettype wire

// [design/osc_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module osc_monitor #(
	parameter int TIMEOUT_CYC = mcu_glue_pkg::OSC_TIMEOUT_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic osc_alive_pin,
	sysctl_if.mon ctl
);
	logic [2:0] sync_ff;
	logic [31:0] cnt_ff;
	logic edge_seen;
	assign edge_seen = sync_ff[2] ^ sync_ff[1];
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sync_ff <= 3'h0;
		end else begin
			sync_ff <= {sync_ff[1:0], osc_alive_pin};
		end
	end
	// counter restarts on every oscillator edge; fires once at timeout
	always_ff @(posedge clk_sys) begin
		if (rst || !ctl.mon_en || edge_seen) begin
			cnt_ff <= 32'h0;
		end else if (cnt_ff < 32'(TIMEOUT_CYC)) begin
			cnt_ff <= cnt_ff + 32'h1;
		end
	end
	assign ctl.osc_timeout = ctl.mon_en && !edge_seen && (cnt_ff == 32'(TIMEOUT_CYC) - 32'h1);
endmodule
`default_nettype wire

// [design/flash_timebase.sv]
`timescale 1ns/100ps
`default_nettype none
module flash_timebase (
	input wire logic clk_sys,
	input wire logic rst,
	sysctl_if.tb ctl
);
	logic [7:0] cnt_ff;
	// divides the bus clock into the program/erase time base
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cnt_ff <= mcu_glue_pkg::ZERO8;
		end else if (cnt_ff == mcu_glue_pkg::ZERO8) begin
			cnt_ff <= ctl.presc;
		end else begin
			cnt_ff <= cnt_ff - 8'h01;
		end
	end
	assign ctl.tick = (cnt_ff == mcu_glue_pkg::ZERO8) && !rst;
endmodule
`default_nettype wire

// [design/mcu_glue_pkg_end.sv]
`timescale 1ns/100ps

// [testbench/cpu_bus_master.sv]
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_master (
	input wire logic clk_sys,
	output logic [17:0] bus_addr,
	output logic bus_valid,
	output logic bus_write
);
	initial begin
		bus_addr = 18'h0_0000;
		bus_valid = 1'b0;
		bus_write = 1'b0;
	end
	// one-cycle access launched just after an edge
	task automatic start(input logic [17:0] a, input logic w);
		@(posedge clk_sys);
		bus_addr <= a;
		bus_valid <= 1'b1;
		bus_write <= w;
	endtask
	// released lines show the inverse of the last value
	task automatic stop();
		@(posedge clk_sys);
		bus_valid <= 1'b0;
		bus_addr <= ~bus_addr;
		bus_write <= ~bus_write;
	endtask
endmodule
`default_nettype wire

// [testbench/mcu_glue_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module mcu_glue_chk #(
	parameter logic [17:0] RAM_SIZE = 18'h0_0800,
	parameter logic [17:0] FLASH_SIZE = 18'h0_8000,
	// identity defaults are arbitrary
	parameter logic [3:0] FAM_MAJOR = 4'h5,
	parameter logic [3:0] FAM_MINOR = 4'ha
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic mode_strap_bit,
	input wire logic die_link_interrupt_input,
	input wire logic irq_unmasked,
	input wire logic stop_exec,
	input wire logic secure_state,
	input wire logic [9:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [17:0] bus_addr,
	input wire logic bus_valid,
	input wire logic bus_write,
	input wire logic sel_periph,
	input wire logic sel_info,
	input wire logic sel_ram,
	input wire logic sel_flash,
	input wire logic sel_zero,
	input wire logic illegal_addr_reset,
	input wire logic osc_mon_reset,
	input wire logic sys_reset_req,
	input wire logic mode_normal,
	input wire logic bdm_active,
	input wire logic run_monitor,
	input wire logic debug_enable,
	input wire logic stop_mode
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	logic [18:0] addr;
	logic in_ram, in_flash, in_gap;
	assign addr = {1'b0, bus_addr};
	assign in_ram = bus_valid && addr >= 19'h0_0800 && addr <= 19'h0_07ff + {1'b0, RAM_SIZE};
	assign in_flash = bus_valid && addr >= 19'h4_0000 - {1'b0, FLASH_SIZE};
	assign in_gap = bus_valid && addr >= 19'h1_0000 && !in_flash;
	sequence s_stop_req;
		!stop_mode && stop_exec;
	endsequence
	sequence s_link_held;
		(stop_mode && die_link_interrupt_input) [*3];
	endsequence
	a_periph_select: assert property (bus_valid && addr <= 19'h0_03ff |-> sel_periph) else $error("periph sel");
	a_info_range: assert property (sel_info |-> addr >= 19'h0_0400 && addr <= 19'h0_047f) else $error("info sel");
	a_reserved_write: assert property (bus_valid && bus_write |-> !sel_zero) else $error("zero on write");
	a_ram_select: assert property (in_ram |-> sel_ram && !sel_flash) else $error("ram sel");
	a_flash_select: assert property (in_flash |-> sel_flash && !sel_ram) else $error("flash sel");
	a_gap_reset: assert property (in_gap |=> illegal_addr_reset && sys_reset_req) else $error("gap reset");
	a_reset_merge: assert property (sys_reset_req == (illegal_addr_reset || osc_mon_reset)) else $error("merge");
	a_id_high: assert property (reg_rd && reg_addr == 10'h01a |=> reg_rdata == {FAM_MAJOR, FAM_MINOR})
		else $error("id high");
	a_mode_capture: assert property ($fell(rst) |=> mode_normal == $past(mode_strap_bit)) else $error("strap");
	a_mode_outputs: assert property (bdm_active == !mode_normal && run_monitor == bdm_active)
		else $error("mode outputs");
	a_debug_gate: assert property (debug_enable == (!mode_normal || !secure_state)) else $error("debug");
	a_stop_entry: assert property (s_stop_req |=> stop_mode) else $error("stop entry");
	a_stop_wake: assert property (stop_mode && irq_unmasked |=> !stop_mode) else $error("irq wake");
	a_link_wake: assert property (s_link_held |-> ##[0:2] !stop_mode) else $error("link wake");
endmodule
bind mcu_glue mcu_glue_chk #(
	.RAM_SIZE(RAM_SIZE),
	.FLASH_SIZE(FLASH_SIZE),
	.FAM_MAJOR(FAM_MAJOR),
	.FAM_MINOR(FAM_MINOR)
) chk (
	.clk_sys(clk_sys),
	.rst(rst),
	.mode_strap_bit(mode_strap_bit),
	.die_link_interrupt_input(die_link_interrupt_input),
	.irq_unmasked(irq_unmasked),
	.stop_exec(stop_exec),
	.secure_state(secure_state),
	.reg_addr(reg_addr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.bus_addr(bus_addr),
	.bus_valid(bus_valid),
	.bus_write(bus_write),
	.sel_periph(sel_periph),
	.sel_info(sel_info),
	.sel_ram(sel_ram),
	.sel_flash(sel_flash),
	.sel_zero(sel_zero),
	.illegal_addr_reset(illegal_addr_reset),
	.osc_mon_reset(osc_mon_reset),
	.sys_reset_req(sys_reset_req),
	.mode_normal(mode_normal),
	.bdm_active(bdm_active),
	.run_monitor(run_monitor),
	.debug_enable(debug_enable),
	.stop_mode(stop_mode)
);
`default_nettype wire

// [testbench/mcu_glue_test.sv]
`timescale 1ns/100ps
`default_nettype none
module mcu_glue_test;
	// part identity value is arbitrary
	localparam logic [15:0] ID = 16'h5a21;
	localparam logic [17:0] RAM_SZ = 18'h0_0800;
	localparam logic [17:0] FLASH_SZ = 18'h0_8000;
	localparam logic [17:0] BASES [7] = '{18'h0_0000, 18'h0_0400, 18'h0_0800, 18'h0_0e00, 18'h0_f000, 18'h3_7c00,
		18'h3_f800};
	logic clk_sys = 1'b0, rst = 1'b1, strap = 1'b0, osc_pin = 1'b0, link = 1'b0, irq = 1'b0, stp = 1'b0, sec = 1'b1;
	logic reg_wr = 1'b0, reg_rd = 1'b0, osc_run = 1'b0, osc_seen = 1'b0, info_en = 1'b0, mm = 1'b0;
	logic [9:0] reg_addr = 10'h000;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic [17:0] bus_addr;
	logic bus_valid, bus_write, sel_periph, sel_info, sel_ram, sel_flash, sel_zero, illegal_addr_reset, osc_mon_reset;
	logic sys_reset_req, mode_normal, fetch_internal, bdm_active, run_monitor, debug_enable, stop_mode, core_clk_run;
	logic clk_src_osc, flash_tick, freeze;
	int n_errors = 0, checks_done = 0, cycles = 0, k = 0;
	cpu_bus_master m (.clk_sys, .bus_addr, .bus_valid, .bus_write);
	mcu_glue #(.RAM_SIZE(RAM_SZ), .FLASH_SIZE(FLASH_SZ), .FAM_MAJOR(ID[15:12]), .FAM_MINOR(ID[11:8]),
		.REV_MAJOR(ID[7:4]), .REV_MINOR(ID[3:0]), .OSC_TIMEOUT_CYC(20)) dut (
		.clk_sys, .rst, .mode_strap_bit(strap), .osc_alive_pin(osc_pin), .die_link_interrupt_input(link),
		.irq_unmasked(irq), .stop_exec(stp), .secure_state(sec), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.bus_addr, .bus_valid, .bus_write, .sel_periph, .sel_info, .sel_ram, .sel_flash, .sel_zero,
		.illegal_addr_reset, .osc_mon_reset, .sys_reset_req, .mode_normal, .fetch_internal, .bdm_active,
		.run_monitor, .debug_enable, .stop_mode, .core_clk_run, .clk_src_osc, .flash_tick, .freeze);
	always #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (osc_run) osc_pin <= ~osc_pin;
	always @(posedge clk_sys) if (osc_mon_reset === 1'b1) osc_seen <= 1'b1;
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_errors = n_errors + 1;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// {periph, info, ram, flash, zero, gap}
	function automatic logic [5:0] model_sel(input logic [17:0] a, input logic w);
		if (a <= 18'h0_03ff) return 6'h20;
		if (a >= 18'h0_0400 && a <= 18'h0_047f) return info_en ? 6'h10 : (w ? 6'h00 : 6'h02);
		if (a >= 18'h0_0800 && a <= 18'h0_07ff + RAM_SZ) return 6'h08;
		if (a >= 18'h0_0000 - FLASH_SZ) return 6'h04;
		if (a >= 18'h1_0000) return 6'h01;
		return w ? 6'h00 : 6'h02;
	endfunction
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		chk("reg_rdata", {10'h0, exp}, {10'h0, reg_rdata});
	endtask
	task automatic chk_mode();
		@(negedge clk_sys);
		chk("mode", {13'h0, mm, mm, ~mm, ~mm, ~mm | ~sec}, {13'h0, mode_normal, fetch_internal, bdm_active,
			run_monitor, debug_enable});
	endtask
	task automatic enter_stop();
		@(posedge clk_sys);
		stp <= 1'b1;
		@(posedge clk_sys);
		stp <= 1'b0;
		@(negedge clk_sys);
		chk("stop", 18'h3, {16'h0, stop_mode, ~core_clk_run});
	endtask
	task automatic tick_gap(output int n);
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (flash_tick !== 1'b1 && n < 300);
	endtask
	task automatic decode_run(input int n);
		logic [17:0] a;
		logic w;
		logic [5:0] e;
		repeat (n) begin
			a = BASES[$urandom_range(0, 6)] + 18'($urandom_range(0, 2047));
			w = 1'($urandom);
			e = model_sel(a, w);
			m.start(a, w);
			@(negedge clk_sys);
			chk("sel", {13'h0, e[5:1]}, {13'h0, sel_periph, sel_info, sel_ram, sel_flash, sel_zero});
			m.stop();
			@(negedge clk_sys);
			chk("illegal", {16'h0, e[0], e[0]}, {16'h0, illegal_addr_reset, sys_reset_req});
		end
	endtask
	initial begin
		void'($urandom(32'hf2e4));
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk_mode();
		rd(10'h01a, ID[15:8]);
		rd(10'h01b, ID[7:0]);
		wr(10'h01b, 8'hff);
		rd(10'h01b, ID[7:0]);
		rd(10'h3ff, 8'h00);
		rd(10'h031, 8'h13);
		rd(10'h032, 8'h1c);
		wr(10'h030, 8'h04);
		@(negedge clk_sys);
		chk("freeze", 18'h1, {17'h0, freeze});
		decode_run(80);
		wr(10'h013, 8'h01);
		info_en = 1'b1;
		decode_run(80);
		@(posedge clk_sys);
		sec <= 1'b0;
		chk_mode();
		@(posedge clk_sys);
		sec <= 1'b1;
		wr(10'h00b, 8'h80);
		mm = 1'b1;
		chk_mode();
		wr(10'h00b, 8'h00);
		chk_mode();
		chk("freeze", 18'h0, {17'h0, freeze});
		@(posedge clk_sys);
		sec <= 1'b0;
		chk_mode();
		@(posedge clk_sys);
		sec <= 1'b1;
		enter_stop();
		@(posedge clk_sys);
		irq <= 1'b1;
		@(posedge clk_sys);
		irq <= 1'b0;
		@(negedge clk_sys);
		chk("irq wake", 18'h0, {16'h0, stop_mode, ~core_clk_run});
		enter_stop();
		@(posedge clk_sys);
		link <= 1'b1;
		repeat (5) @(posedge clk_sys);
		link <= 1'b0;
		@(negedge clk_sys);
		chk("link wake", 18'h0, {17'h0, stop_mode});
		wr(10'h031, 8'h03);
		wr(10'h030, 8'h01);
		@(negedge clk_sys);
		chk("clk_src_osc", 18'h1, {17'h0, clk_src_osc});
		repeat (3) tick_gap(k);
		chk("tick period", 18'h4, 18'(k));
		osc_run <= 1'b1;
		wr(10'h030, 8'h02);
		repeat (60) @(posedge clk_sys);
		osc_run <= 1'b0;
		repeat (16) @(posedge clk_sys);
		chk("osc early", 18'h0, {17'h0, osc_seen});
		repeat (16) @(posedge clk_sys);
		chk("osc timeout", 18'h1, {17'h0, osc_seen});
		rst <= 1'b1;
		strap <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk_mode();
		rd(10'h030, 8'h00);
		wrap_up();
	end
endmodule
`default_nettype wire
